//--- rtl/cmt_timers.sv
// Connection and noise timers with parameter registers behind an APB slave
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps

// Contract
// [R1] Connection timer is 16 bits, read-only at offset 0x12 normally.
// [R2] Connection timer advances on carry of an 8-bit prescaler, every 256 clocks.
// [R3] Connection prescaler value reads in bits 7..0 at offset 0x14.
// [R4] Timers load two's complement start values, count up; zero means expiry.
// [R5] Manager load from parameter registers clears connection prescaler too.
// [R6] In maintenance, write to 0x0E loads connection timer, clears its prescaler.
// [R7] Outside maintenance that write is ignored and sets processor error flag.
// [R8] Connection undivided mode bypasses prescaler, counting every clock.
// [R9] Noise timer is 16 bits, read-only at offset 0x13 normally.
// [R10] Write to 0x0F loads noise timer only in maintenance, noise mode clear.
// [R11] Noise timer advances on carry of a 2-bit prescaler, every four clocks.
// [R12] Noise prescaler value reads in bits 9 and 8 at offset 0x14.
// [R13] While active, noise timer starts when line leaves idle for noise/active/unknown.
// [R14] Noise expiry before idle returns forces teardown; the code does so only while pcm_active_in is set.
// [R15] Leaving idle loads noise timer from noise limit, clears noise prescaler.
// [R16] Noise load write with maintenance noise timing set is refused, error flagged.
// [R17] Maintenance noise timing times noise in maintenance without processor load.
// [R18] Noise undivided mode bypasses prescaler, counting every clock.
// [R19] Timing parameter registers are 16-bit, readable any time.
// [R20] Noise limit feeds noise timer; offsets 0x06 to 0x0C feed connection timer.
// [R21] Awaited response not seen before signaling timeout forces teardown.
// [R22] Software should program recommended values FFB2, FFFE, FF10, ECED.
// [R23] Teardown reason 010 on signaling timeout, 011 on noise limit.
// [R24] Expired timer holds zero, pulses expiry once until reloaded.
module cmt_timers
  import cmt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic maintenance_state_state_in,
  input wire logic pcm_active_in,
  input wire cmt_line_t line_state_in,
  input wire logic conn_load_in,
  input wire logic [2:0] conn_param_sel_in,
  input wire logic awaiting_response_in,
  output logic conn_expired_out,
  output logic noise_expired_out,
  output logic teardown_req_out,
  output logic [2:0] teardown_reason_out,
  output logic processor_error_out
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] param_slot(input logic [5:0] idx);
    case (idx)
      IDX_MIN_CONNECT: param_slot = 3'h0;
      IDX_MIN_LINE_STATE: param_slot = 3'h1;
      IDX_MIN_TEARDOWN: param_slot = 3'h2;
      IDX_SIGNALING_TIMEOUT: param_slot = 3'h3;
      IDX_CONFIDENCE_LENGTH: param_slot = 3'h4;
      IDX_CLEANUP_TIME: param_slot = 3'h5;
      IDX_NOISE_LIMIT: param_slot = SLOT_NOISE_LIMIT;
      default: param_slot = SLOT_NONE;
    endcase
  endfunction

  function automatic logic [5:0] sel_index(input logic [2:0] sel);
    case (sel)
      3'h0: sel_index = IDX_MIN_CONNECT;
      3'h1: sel_index = IDX_MIN_LINE_STATE;
      3'h2: sel_index = IDX_MIN_TEARDOWN;
      3'h3: sel_index = IDX_SIGNALING_TIMEOUT;
      3'h4: sel_index = IDX_CONFIDENCE_LENGTH;
      default: sel_index = IDX_CLEANUP_TIME;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [TIMER_W-1:0] params_r [NUM_PARAMS];
  cmt_ctrl_t ctrl_r;
  logic err_flag_r;
  logic [TIMER_W-1:0] conn_r;
  logic [TIMER_W-1:0] noise_r;
  logic [CPRE_W-1:0] cpre_r;
  logic [NPRE_W-1:0] npre_r;
  logic conn_run_r;
  logic noise_run_r;
  cmt_line_t line_prev_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic conn_exp_r;
  logic noise_exp_r;
  logic teardown_r;
  logic [2:0] reason_r;

  logic [5:0] idx;
  logic setup;
  logic wr_done;
  logic mapped;
  logic wr_conn_load;
  logic wr_noise_load;
  logic conn_load_ok;
  logic noise_load_ok;
  logic wr_error;
  logic [2:0] wslot;
  logic [2:0] cslot;
  logic leave_idle;
  logic noise_start;
  logic noise_enable;
  logic conn_tick;
  logic noise_tick;
  logic conn_hit;
  logic noise_hit;
  logic [31:0] rd_data;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign idx = paddr_in[ADDR_LSB+5:ADDR_LSB];
  assign setup = psel_in && !penable_in;
  assign wr_done = psel_in && penable_in && pready_r && pwrite_in;
  assign wslot = param_slot(idx);
  assign cslot = param_slot(sel_index(conn_param_sel_in));
  assign wr_conn_load = wr_done && (idx == IDX_CONN_TIMER_LOAD);
  assign wr_noise_load = wr_done && (idx == IDX_NOISE_TIMER_LOAD);
  assign conn_load_ok = wr_conn_load && maintenance_state_state_in; // [R6]
  assign noise_load_ok = wr_noise_load && maintenance_state_state_in
                         && !ctrl_r.maintenance_state_noise_timing; // [R10]
  assign wr_error = (wr_conn_load && !maintenance_state_state_in)
                    || (wr_noise_load && !noise_load_ok); // [R7] [R16]

  always_comb
  begin
    mapped = 1'b1;
    rd_data = '0;
    if (param_slot(idx) != SLOT_NONE)
    begin
      rd_data[TIMER_W-1:0] = params_r[param_slot(idx)]; // [R19]
    end
    else
    begin
      case (idx)
        IDX_CONTROL_A: rd_data[CTRL_W-1:0] = ctrl_r;
        IDX_EVENT_FLAGS: rd_data[0] = err_flag_r;
        IDX_CONN_TIMER_LOAD: rd_data = '0;
        IDX_NOISE_TIMER_LOAD: rd_data = '0;
        IDX_CONN_TIMER_VALUE: rd_data[TIMER_W-1:0] = conn_r; // [R1]
        IDX_NOISE_TIMER_VALUE: rd_data[TIMER_W-1:0] = noise_r; // [R9]
        IDX_PRESCALER_STATE:
        begin
          rd_data[CPRE_W-1:0] = cpre_r; // [R3]
          rd_data[NPRE_LSB+NPRE_W-1:NPRE_LSB] = npre_r; // [R12]
        end
        default: mapped = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB answer, one wait-free access phase
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= setup && !mapped;
      prdata_r <= (setup && !pwrite_in) ? rd_data : '0;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < NUM_PARAMS; i++)
      begin
        params_r[i] <= PARAM_RESET;
      end
    end
    else if (wr_done && wslot != SLOT_NONE)
    begin
      params_r[wslot] <= pwdata_in[TIMER_W-1:0]; // [R19] [R22]
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_r <= CTRL_RESET;
    end
    else if (wr_done && idx == IDX_CONTROL_A)
    begin
      ctrl_r <= cmt_ctrl_t'(pwdata_in[CTRL_W-1:0]);
    end
  end

  // Error flag: write one to clear, a new error wins
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      err_flag_r <= 1'b0;
    end
    else if (wr_error)
    begin
      err_flag_r <= 1'b1; // [R7] [R16]
    end
    else if (wr_done && idx == IDX_EVENT_FLAGS && pwdata_in[0])
    begin
      err_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Connection timer and prescaler
  // ----------------------------------------------------------------
  assign conn_tick = ctrl_r.conn_timer_undivided || (&cpre_r); // [R2] [R8]
  assign conn_hit = conn_run_r && (conn_r == TIMER_ZERO);

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      conn_r <= TIMER_ZERO;
      cpre_r <= '0;
      conn_run_r <= 1'b0;
      conn_exp_r <= 1'b0;
    end
    else
    begin
      conn_exp_r <= conn_hit; // [R24]
      if (conn_load_ok)
      begin
        conn_r <= pwdata_in[TIMER_W-1:0]; // [R6]
        cpre_r <= '0;
        conn_run_r <= 1'b1;
      end
      else if (conn_load_in)
      begin
        conn_r <= params_r[cslot]; // [R5] [R20]
        cpre_r <= '0;
        conn_run_r <= 1'b1;
      end
      else
      begin
        cpre_r <= cpre_r + 1'b1; // [R2]
        if (conn_hit)
        begin
          conn_run_r <= 1'b0; // [R4] [R24]
        end
        else if (conn_run_r && conn_tick)
        begin
          conn_r <= conn_r + 1'b1; // [R4]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Noise timer and prescaler
  // ----------------------------------------------------------------
  assign leave_idle = (line_prev_r == LS_IDLE) && (line_state_in != LS_IDLE);
  assign noise_enable = pcm_active_in
                        || (maintenance_state_state_in && ctrl_r.maintenance_state_noise_timing); // [R17]
  assign noise_start = leave_idle && noise_enable
                       && (line_state_in == LS_NOISE || line_state_in == LS_ACTIVE
                           || line_state_in == LS_UNKNOWN); // [R13]
  assign noise_tick = ctrl_r.noise_timer_undivided || (&npre_r); // [R11] [R18]
  assign noise_hit = noise_run_r && (noise_r == TIMER_ZERO);

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      line_prev_r <= LS_QUIET;
    end
    else
    begin
      line_prev_r <= line_state_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      noise_r <= TIMER_ZERO;
      npre_r <= '0;
      noise_run_r <= 1'b0;
      noise_exp_r <= 1'b0;
    end
    else
    begin
      noise_exp_r <= noise_hit; // [R24]
      if (leave_idle)
      begin
        noise_r <= params_r[SLOT_NOISE_LIMIT]; // [R15] [R20]
        npre_r <= '0;
        noise_run_r <= noise_start; // [R13]
      end
      else if (noise_load_ok)
      begin
        noise_r <= pwdata_in[TIMER_W-1:0]; // [R10]
        npre_r <= '0;
        noise_run_r <= 1'b1;
      end
      else
      begin
        npre_r <= npre_r + 1'b1; // [R11]
        if (noise_hit || line_state_in == LS_IDLE)
        begin
          noise_run_r <= 1'b0; // [R14] [R24]
        end
        else if (noise_run_r && noise_tick)
        begin
          noise_r <= noise_r + 1'b1; // [R4]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Teardown request and reason
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      teardown_r <= 1'b0;
      reason_r <= REASON_NONE;
    end
    else
    begin
      teardown_r <= 1'b0;
      if (noise_hit && pcm_active_in && line_state_in != LS_IDLE)
      begin
        teardown_r <= 1'b1; // [R14]
        reason_r <= REASON_NOISE; // [R23]
      end
      else if (conn_hit && awaiting_response_in)
      begin
        teardown_r <= 1'b1; // [R21]
        reason_r <= REASON_SIG_TIMEOUT; // [R23]
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign conn_expired_out = conn_exp_r;
  assign noise_expired_out = noise_exp_r;
  assign teardown_req_out = teardown_r;
  assign teardown_reason_out = reason_r;
  assign processor_error_out = err_flag_r;

endmodule

//--- rtl/cmt_pkg.sv
// Package: register map, field layout and types of the connection timers
package cmt_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CONTROL_A = 6'h01;
  localparam logic [5:0] IDX_EVENT_FLAGS = 6'h02;
  localparam logic [5:0] IDX_MIN_CONNECT = 6'h06;
  localparam logic [5:0] IDX_MIN_LINE_STATE = 6'h07;
  localparam logic [5:0] IDX_MIN_TEARDOWN = 6'h08;
  localparam logic [5:0] IDX_SIGNALING_TIMEOUT = 6'h09;
  localparam logic [5:0] IDX_CONFIDENCE_LENGTH = 6'h0B;
  localparam logic [5:0] IDX_CLEANUP_TIME = 6'h0C;
  localparam logic [5:0] IDX_NOISE_LIMIT = 6'h0D;
  localparam logic [5:0] IDX_CONN_TIMER_LOAD = 6'h0E;
  localparam logic [5:0] IDX_NOISE_TIMER_LOAD = 6'h0F;
  localparam logic [5:0] IDX_CONN_TIMER_VALUE = 6'h12;
  localparam logic [5:0] IDX_NOISE_TIMER_VALUE = 6'h13;
  localparam logic [5:0] IDX_PRESCALER_STATE = 6'h14;
  localparam int ADDR_LSB = 2;

  // ----------------------------------------------------------------
  // Parameter slots and widths
  // ----------------------------------------------------------------
  localparam int NUM_PARAMS = 7;
  localparam logic [2:0] SLOT_NONE = 3'h7;
  localparam logic [2:0] SLOT_NOISE_LIMIT = 3'h6;
  localparam int TIMER_W = 16;
  localparam int CPRE_W = 8;
  localparam int NPRE_W = 2;
  localparam int NPRE_LSB = 8;
  localparam logic [15:0] PARAM_RESET = 16'h0000;
  localparam logic [15:0] TIMER_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 80;
  localparam int TICK_NS = 80;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Teardown reason codes
  // ----------------------------------------------------------------
  localparam logic [2:0] REASON_NONE = 3'h0;
  localparam logic [2:0] REASON_SIG_TIMEOUT = 3'h2;
  localparam logic [2:0] REASON_NOISE = 3'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LS_QUIET,
    LS_IDLE,
    LS_NOISE,
    LS_ACTIVE,
    LS_UNKNOWN,
    LS_HALT,
    LS_MASTER
  } cmt_line_t;

  typedef struct packed {
    logic maintenance_state_noise_timing;
    logic noise_timer_undivided;
    logic conn_timer_undivided;
  } cmt_ctrl_t;

  localparam cmt_ctrl_t CTRL_RESET = '0;
  localparam int CTRL_W = 3;
endpackage

//--- testbench/cmt_timers_asserts.sv
// Checker for the APB and timer outputs of the connection timers
`timescale 1ns/1ps
module cmt_timers_asserts
  import cmt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic maintenance_state_state_in,
  input wire logic conn_expired_out,
  input wire logic noise_expired_out,
  input wire logic teardown_req_out,
  input wire logic [2:0] teardown_reason_out,
  input wire logic processor_error_out
);
  logic [5:0] idx;
  assign idx = paddr_in[7:2];
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence setup_s;
    psel_in && !penable_in;
  endsequence
  sequence commit_s;
    psel_in && penable_in && pready_out && pwrite_in;
  endsequence
  chk_ready_next: assert property (setup_s |=> pready_out)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  chk_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  chk_idle_data: assert property (!pready_out |-> prdata_out == 32'h00000000)
    else $error("read data outside access");
  chk_upper_zero: assert property (pready_out |-> prdata_out[31:16] == 16'h0000)
    else $error("upper read bits set");
  chk_load_refused: assert property (commit_s ##0 (!maintenance_state_state_in &&
    (idx == IDX_CONN_TIMER_LOAD || idx == IDX_NOISE_TIMER_LOAD)) |=> processor_error_out)
    else $error("refused load not flagged");
  chk_err_clear: assert property ($fell(processor_error_out) |->
    $past(psel_in && penable_in && pwrite_in && idx == IDX_EVENT_FLAGS && pwdata_in[0]))
    else $error("error flag lost");
  chk_tear_cause: assert property (teardown_req_out |->
    (noise_expired_out && teardown_reason_out == REASON_NOISE) ||
    (!noise_expired_out && conn_expired_out && teardown_reason_out == REASON_SIG_TIMEOUT))
    else $error("teardown cause wrong");
  chk_conn_pulse: assert property (conn_expired_out |=> !conn_expired_out)
    else $error("connection expiry not single");
  chk_noise_pulse: assert property (noise_expired_out |=> !noise_expired_out)
    else $error("noise expiry not single");
endmodule

bind cmt_timers cmt_timers_asserts u_asserts (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .maintenance_state_state_in(maintenance_state_state_in),
  .conn_expired_out(conn_expired_out), .noise_expired_out(noise_expired_out),
  .teardown_req_out(teardown_req_out), .teardown_reason_out(teardown_reason_out),
  .processor_error_out(processor_error_out));

//--- testbench/tb_cmt_timers.sv
// Self-checking bench for the connection and noise timers
`timescale 1ns/1ps
module tb_cmt_timers
  import cmt_pkg::*;
;
  logic clk_in, rst_n_in, psel, penable, pwrite, maintenance_state, active, cload, awaiting;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, cexp, nexp, tear, perr;
  logic [2:0] csel, reason;
  cmt_line_t line;
  cmt_line_t st [3] = '{LS_NOISE, LS_ACTIVE, LS_UNKNOWN};
  logic [5:0] pidx [7] = '{IDX_MIN_CONNECT, IDX_MIN_LINE_STATE, IDX_MIN_TEARDOWN,
    IDX_SIGNALING_TIMEOUT, IDX_CONFIDENCE_LENGTH, IDX_CLEANUP_TIME, IDX_NOISE_LIMIT};
  logic [15:0] rec [4] = '{16'hFFB2, 16'hFFFE, 16'hFF10, 16'hECED};
  int bad_count, tests_run;

  cmt_timers DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .maintenance_state_state_in(maintenance_state),
    .pcm_active_in(active), .line_state_in(line), .conn_load_in(cload),
    .conn_param_sel_in(csel), .awaiting_response_in(awaiting), .conn_expired_out(cexp),
    .noise_expired_out(nexp), .teardown_req_out(tear), .teardown_reason_out(reason),
    .processor_error_out(perr));

  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge clk_in);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_in);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 16'h0000);
    chk(rd, exp);
  endtask

  task expire(input logic noise, input int want);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while ((noise ? nexp : cexp) !== 1'b1 && n < 400);
    chk(n, want);
  endtask

  task results();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #(100 * 6000);
    bad_count++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst_n_in, psel, penable, pwrite, maintenance_state, active, cload, awaiting} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    csel = 3'h0;
    line = LS_IDLE;
    bad_count = 0;
    tests_run = 0;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      rdc(pidx[i], 32'h00000000);
      apb(1'b1, pidx[i], 16'hFFF0 + i[15:0]);
      rdc(pidx[i], {16'h0000, 16'hFFF0 + i[15:0]});
    end
    rdc(6'h0A, 32'h00000000);
    chk(er, 1'b1);
    $display("test registers done");
    apb(1'b1, IDX_CONTROL_A, 16'h0003);
    for (int i = 0; i < 7; i++)
    begin
      csel <= i[2:0];
      awaiting <= (i == 3);
      cload <= 1'b1;
      @(posedge clk_in);
      cload <= 1'b0;
      expire(1'b0, (i < 6) ? 18 - i : 13);
      chk(tear, i == 3);
      if (i == 3)
        chk(reason, REASON_SIG_TIMEOUT);
    end
    awaiting <= 1'b0;
    $display("test connection loads done");
    active <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      line <= LS_IDLE;
      @(posedge clk_in);
      line <= st[k];
      expire(1'b1, 13);
      chk(tear, 1'b1);
      chk(reason, REASON_NOISE);
    end
    line <= LS_IDLE;
    @(posedge clk_in);
    line <= LS_NOISE;
    repeat (5) @(posedge clk_in);
    line <= LS_IDLE;
    expire(1'b1, 400);
    active <= 1'b0;
    $display("test noise bursts done");
    apb(1'b1, IDX_CONTROL_A, 16'h0000);
    apb(1'b1, IDX_CONN_TIMER_LOAD, 16'hFF00);
    rdc(IDX_CONN_TIMER_VALUE, 32'h00000000);
    rdc(IDX_EVENT_FLAGS, 32'h00000001);
    chk(perr, 1'b1);
    apb(1'b1, IDX_EVENT_FLAGS, 16'h0001);
    apb(1'b1, IDX_CONN_TIMER_VALUE, 16'h1234);
    chk(er, 1'b0);
    rdc(IDX_EVENT_FLAGS, 32'h00000000);
    maintenance_state <= 1'b1;
    apb(1'b1, IDX_NOISE_TIMER_LOAD, 16'hFF00);
    rdc(IDX_NOISE_TIMER_VALUE, 32'h0000FF00);
    apb(1'b1, IDX_CONN_TIMER_LOAD, 16'hFF00);
    rdc(IDX_CONN_TIMER_VALUE, 32'h0000FF00);
    apb(1'b0, IDX_PRESCALER_STATE, 16'h0000);
    chk(rd, 32'h00000204);
    apb(1'b1, IDX_CONN_TIMER_LOAD, 16'hFFFF);
    expire(1'b0, 258);
    line <= LS_NOISE;
    apb(1'b1, IDX_NOISE_TIMER_LOAD, 16'hFFFF);
    expire(1'b1, 6);
    line <= LS_IDLE;
    apb(1'b1, IDX_CONTROL_A, 16'h0004);
    apb(1'b1, IDX_NOISE_TIMER_LOAD, 16'hFF00);
    rdc(IDX_EVENT_FLAGS, 32'h00000001);
    rdc(IDX_NOISE_TIMER_VALUE, 32'h00000000);
    line <= LS_NOISE;
    expire(1'b1, 43);
    line <= LS_IDLE;
    maintenance_state <= 1'b0;
    $display("test processor loads done");
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, pidx[i], rec[i]);
      rdc(pidx[i], {16'h0000, rec[i]});
    end
    $display("test recommended values done");
    results();
  end
endmodule
